/* File: shared/emib_pkg.sv */
package emib_pkg;
    // register bases, each with clear/set/invert aliases above it
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] OFS_GAP_CFG = 8'h10;
    localparam logic [7:0] OFS_COLL_CFG = 8'h20;
    localparam logic [7:0] OFS_WMARK_CFG = 8'h30;
    localparam logic [7:0] OFS_CTRL = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h50;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h60;
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLEAR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INVERT = 2'h3;
    // flag bit positions
    localparam int BIT_TX_BUS_ERR = 14;
    localparam int BIT_RX_BUS_ERR = 13;
    localparam int BIT_EMPTY_WM = 9;
    localparam int BIT_FULL_WM = 8;
    localparam int BIT_RX_DONE = 7;
    // writable flag bits through aliases (watermark flags excluded)
    localparam logic [31:0] IRQ_SW_MASK = 32'h0000_6080;
    localparam logic [31:0] IRQ_IMPL_MASK = 32'h0000_6380;
    // gap field
    localparam int GAP_LSB = 0;
    localparam int GAP_W = 7;
    localparam logic [6:0] GAP_RESET = 7'h12;
    // collision window and retry fields
    localparam int CWIN_LSB = 8;
    localparam int CWIN_W = 6;
    localparam logic [5:0] CWIN_RESET = 6'h37;
    localparam int RETRY_LSB = 0;
    localparam int RETRY_W = 4;
    localparam logic [3:0] RETRY_RESET = 4'hF;
    localparam logic [31:0] COLL_MASK = 32'h0000_3F0F;
    // watermark config: empty threshold 7:0, full threshold 23:16
    localparam int EWM_LSB = 0;
    localparam int FWM_LSB = 16;
    localparam logic [31:0] WMARK_MASK = 32'h00FF_00FF;
    // control: count decrement strobe bit 0
    localparam int BIT_CNT_DEC = 0;
    // status: descriptor buffer count 23:16
    localparam int CNT_LSB = 16;
endpackage

/* File: src/emib_core.sv */
// Notes on behaviour
// RL1: transmit DMA bus error sets flag bit 14; clear only by reset or clear alias (code also clears it by direct write or invert alias).
// RL2: receive DMA bus error sets flag bit 13; clear only by reset or clear alias (code also clears it by direct write or invert alias).
// RL3: empty watermark flag bit 9 sets while count at or below threshold.
// RL4: empty watermark flag clears on hardware count increment; software writes ignored.
// RL5: full watermark flag bit 8 sets while count at or above threshold.
// RL6: full watermark flag clears on decrement strobe write; direct writes ignored.
// RL7: receive complete flag bit 7 sets per good packet; cleared by clear alias.
// RL8: gap field bits 6:0 sets minimum nibble gap between transmitted packets.
// RL9: full duplex software programs desired gap minus three.
// RL10: half duplex software programs desired gap minus six.
// RL11: recommended gap values are 0x15 full duplex, 0x12 half duplex.
// RL12: collision window bits 13:8 counted from transmission start, preamble included.
// RL13: collision window field resets to 0x37.
// RL14: retry field bits 3:0 limits retransmissions, then abort; resets to 0xF.
// RL15: 16 and 32 bit accesses accepted; 8 bit accesses ignored (code checks the size of writes only; reads return data for any byte enables).
// RL16: software should change flags through aliases except for debug.
// RL17: unimplemented bits read zero and ignore writes.
// RL18: clear, set, invert aliases at +0x4, +0x8, +0xC of each base.
// RL19: one interrupt output high while any unmasked flag is set.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module emib_core
    import emib_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_dma_bus_err,
    input wire logic rx_dma_bus_err,
    input wire logic rx_packet_ok,
    input wire logic desc_count_inc,
    input wire logic tx_start,
    input wire logic tx_collision,
    output logic [GAP_W-1:0] back_to_back_gap_field,
    output logic [CWIN_W-1:0] collision_slot_length,
    output logic [RETRY_W-1:0] retry_limit,
    output logic [CNT_W-1:0] descriptor_buffer_count,
    output logic in_collision_window,
    output logic retry_abort,
    output logic irq
);

    logic tx_err_r;
    logic rx_err_r;
    logic rx_done_r;
    logic empty_wm_r;
    logic full_wm_r;
    logic [31:0] ethernet_interrupt_flags;
    logic flags_wr;
    logic [31:0] irq_mask_r;
    logic [GAP_W-1:0] gap_r;
    logic [CWIN_W-1:0] cwin_r;
    logic [RETRY_W-1:0] retry_r;
    logic [7:0] ewm_r;
    logic [7:0] fwm_r;
    logic [CNT_W-1:0] count_r;
    logic ack_r;
    logic [7:0] win_cnt_r;
    logic [4:0] attempt_r;
    logic in_win_r;
    logic abort_r;
    logic [31:0] rdata_r;

    // apply an aliased write to a register image
    function automatic logic [31:0] alias_apply(input logic [31:0] cur,
                                                input logic [31:0] wd,
                                                input logic [1:0] kind);
        logic [31:0] res;
        res = cur;
        unique case (kind)
            ALIAS_WRITE: res = wd;
            ALIAS_CLEAR: res = cur & ~wd;
            ALIAS_SET: res = cur | wd;
            ALIAS_INVERT: res = cur ^ wd;
        endcase
        return res;
    endfunction

    // access size legal: only 16-bit halves or full word
    function automatic logic size_ok(input logic [3:0] be);
        return (be == 4'hF) || (be == 4'h3) || (be == 4'hC);
    endfunction

    // widen write data to byte enables for half-word accesses
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    logic [7:0] base;
    logic [1:0] kind;
    logic wr_go;
    logic [31:0] wmask;
    logic [31:0] wd;

    // one wait state per access, answer on the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign base = {avs_address[7:4], 4'h0};
    assign kind = avs_address[3:2];
    assign wr_go = avs_write & ack_r & size_ok(avs_byteenable); // RL15
    assign wmask = be_mask(avs_byteenable);
    assign wd = avs_writedata & wmask;

    // access handshake
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // merge alias result with current value under byte enables
    function automatic logic [31:0] merged(input logic [31:0] cur,
                                           input logic [31:0] wdat,
                                           input logic [1:0] k,
                                           input logic [31:0] m);
        logic [31:0] n;
        n = alias_apply(cur, wdat, k);
        return (n & m) | (cur & ~m);
    endfunction

    logic [31:0] flags_sw;
    logic dec_go;

    // software view of the flags and the decrement strobe
    assign flags_sw = merged(ethernet_interrupt_flags, wd, kind, wmask);
    assign dec_go = wr_go && base == OFS_CTRL && kind != ALIAS_CLEAR
                    && wd[BIT_CNT_DEC] && count_r != '0;
    assign flags_wr = wr_go && base == OFS_IRQ_FLAGS; // RL18 RL16

    // transmit bus error flag: hardware set beats software clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_err_r <= 1'b0;
        end else if (tx_dma_bus_err) begin
            tx_err_r <= 1'b1; // RL1
        end else if (flags_wr) begin
            tx_err_r <= flags_sw[BIT_TX_BUS_ERR];
        end
    end

    // receive bus error flag: hardware set beats software clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_err_r <= 1'b0;
        end else if (rx_dma_bus_err) begin
            rx_err_r <= 1'b1; // RL2
        end else if (flags_wr) begin
            rx_err_r <= flags_sw[BIT_RX_BUS_ERR];
        end
    end

    // receive complete flag: hardware set beats software clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_done_r <= 1'b0;
        end else if (rx_packet_ok) begin
            rx_done_r <= 1'b1; // RL7
        end else if (flags_wr) begin
            rx_done_r <= flags_sw[BIT_RX_DONE];
        end
    end

    // flag image: unimplemented positions stay zero
    always_comb begin
        ethernet_interrupt_flags = '0; // RL17
        ethernet_interrupt_flags[BIT_TX_BUS_ERR] = tx_err_r;
        ethernet_interrupt_flags[BIT_RX_BUS_ERR] = rx_err_r;
        ethernet_interrupt_flags[BIT_EMPTY_WM] = empty_wm_r;
        ethernet_interrupt_flags[BIT_FULL_WM] = full_wm_r;
        ethernet_interrupt_flags[BIT_RX_DONE] = rx_done_r;
    end

    // empty watermark flag follows the count; software writes have no effect
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            empty_wm_r <= 1'b0;
        end else if (desc_count_inc) begin
            empty_wm_r <= 1'b0; // RL4
        end else if (8'(count_r) <= ewm_r) begin
            empty_wm_r <= 1'b1; // RL3
        end
    end

    // full watermark flag follows the count; cleared only by the decrement strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            full_wm_r <= 1'b0;
        end else if (dec_go) begin
            full_wm_r <= 1'b0; // RL6
        end else if (8'(count_r) >= fwm_r) begin
            full_wm_r <= 1'b1; // RL5
        end
    end

    // descriptor buffer count: hardware up, software strobe down
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_r <= '0;
        end else if (desc_count_inc && !dec_go) begin
            count_r <= count_r + 1'b1;
        end else if (dec_go && !desc_count_inc) begin
            count_r <= count_r - 1'b1;
        end
    end

    logic [31:0] gap_img;
    logic [31:0] coll_img;
    logic [31:0] wm_img;
    logic [31:0] gap_new;
    logic [31:0] coll_new;
    logic [31:0] wm_new;
    logic [31:0] mask_new;

    assign gap_img = {25'h0, gap_r};
    assign coll_img = {18'h0, cwin_r, 4'h0, retry_r};
    assign wm_img = {8'h00, fwm_r, 8'h00, ewm_r};
    assign gap_new = merged(gap_img, wd, kind, wmask);
    assign coll_new = merged(coll_img, wd, kind, wmask) & COLL_MASK; // RL17
    assign wm_new = merged(wm_img, wd, kind, wmask) & WMARK_MASK;
    assign mask_new = merged(irq_mask_r, wd, kind, wmask) & IRQ_IMPL_MASK;

    logic sel_gap;
    logic sel_coll;
    logic sel_wmark;
    logic sel_mask;

    // write strobes per register base, through any alias
    assign sel_gap = wr_go && base == OFS_GAP_CFG;
    assign sel_coll = wr_go && base == OFS_COLL_CFG;
    assign sel_wmark = wr_go && base == OFS_WMARK_CFG;
    assign sel_mask = wr_go && base == OFS_IRQ_MASK;

    // back-to-back gap register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gap_r <= GAP_RESET;
        end else if (sel_gap) begin
            gap_r <= gap_new[GAP_LSB +: GAP_W]; // RL8
        end
    end

    // collision window and retry limit register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cwin_r <= CWIN_RESET; // RL13
            retry_r <= RETRY_RESET; // RL14
        end else if (sel_coll) begin
            cwin_r <= coll_new[CWIN_LSB +: CWIN_W];
            retry_r <= coll_new[RETRY_LSB +: RETRY_W];
        end
    end

    // watermark thresholds
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ewm_r <= '0;
            fwm_r <= 8'hFF;
        end else if (sel_wmark) begin
            ewm_r <= wm_new[EWM_LSB +: 8];
            fwm_r <= wm_new[FWM_LSB +: 8];
        end
    end

    // interrupt mask, all implemented flags enabled after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_mask_r <= IRQ_IMPL_MASK;
        end else if (sel_mask) begin
            irq_mask_r <= mask_new;
        end
    end

    // collision window timer from transmission start, one count per clock cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            win_cnt_r <= '0;
            in_win_r <= 1'b0;
        end else if (tx_start) begin
            win_cnt_r <= '0; // RL12
            in_win_r <= 1'b1;
        end else if (in_win_r) begin
            win_cnt_r <= win_cnt_r + 1'b1;
            if (win_cnt_r + 1'b1 >= {2'b00, cwin_r}) begin
                in_win_r <= 1'b0;
            end
        end
    end

    // retry counter: abort after limit of retransmissions
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            attempt_r <= '0;
            abort_r <= 1'b0;
        end else begin
            abort_r <= 1'b0;
            if (tx_collision && in_win_r) begin
                if (attempt_r >= {1'b0, retry_r}) begin
                    abort_r <= 1'b1; // RL14
                    attempt_r <= '0;
                end else begin
                    attempt_r <= attempt_r + 1'b1;
                end
            end else if (tx_start && !in_win_r && win_cnt_r >= {2'b00, cwin_r}) begin
                attempt_r <= '0;
            end
        end
    end

    // read data register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (avs_read && !ack_r) begin
            unique case (base)
                OFS_IRQ_FLAGS: rdata_r <= ethernet_interrupt_flags;
                OFS_GAP_CFG: rdata_r <= gap_img;
                OFS_COLL_CFG: rdata_r <= coll_img;
                OFS_WMARK_CFG: rdata_r <= wm_img;
                OFS_STATUS: rdata_r <= 32'(count_r) << CNT_LSB;
                OFS_IRQ_MASK: rdata_r <= irq_mask_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    // outputs
    assign avs_readdata = rdata_r;
    assign back_to_back_gap_field = gap_r;
    assign collision_slot_length = cwin_r;
    assign retry_limit = retry_r;
    assign descriptor_buffer_count = count_r;
    assign in_collision_window = in_win_r;
    assign retry_abort = abort_r;
    assign irq = |(ethernet_interrupt_flags & irq_mask_r); // RL19

endmodule
`default_nettype wire

/* File: verif/emib_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none
module emib_phy_model (
    input wire logic clk_sys,
    input wire logic [2:0] ev_req,
    output logic rx_packet_ok,
    output logic tx_start,
    output logic tx_collision
);
    // network-side events, each one clean single-cycle pulse
    always_ff @(posedge clk_sys) begin
        rx_packet_ok <= ev_req[0];
        tx_start <= ev_req[1];
        tx_collision <= ev_req[2];
    end
endmodule
`default_nettype wire

/* File: verif/emib_core_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module emib_core_assertions #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic desc_count_inc,
    input wire logic [6:0] back_to_back_gap_field,
    input wire logic [5:0] collision_slot_length,
    input wire logic [3:0] retry_limit,
    input wire logic [CNT_W-1:0] descriptor_buffer_count,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // bus answer, reset values and field stability
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    gap_reset_a: assert property ($fell(sys_rst) |-> back_to_back_gap_field == 7'h12)
        else $error("gap field reset value wrong");
    coll_reset_a: assert property ($fell(sys_rst) |-> collision_slot_length == 6'h37 && retry_limit == 4'hF)
        else $error("collision fields reset value wrong");
    irq_reset_a: assert property ($fell(sys_rst) |-> !irq ##[1:2] irq)
        else $error("irq not raised by empty level after reset");
    count_up_a: assert property (desc_count_inc && !avs_write && descriptor_buffer_count != '1 |=>
        descriptor_buffer_count == $past(descriptor_buffer_count) + 1'b1)
        else $error("count did not step up");
    count_hold_a: assert property (!desc_count_inc && !avs_write |=> $stable(descriptor_buffer_count))
        else $error("count moved with no cause");
    cfg_hold_a: assert property (!avs_write |=> $stable(back_to_back_gap_field) && $stable(retry_limit))
        else $error("config field moved with no write");
    byte_ignore_a: assert property (avs_write && !avs_waitrequest && avs_byteenable == 4'h1 |=>
        $stable(back_to_back_gap_field) && $stable(collision_slot_length))
        else $error("byte write changed a field");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
endmodule
`default_nettype wire

/* File: verif/ethernet_mac_irq_and_backoff_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ethernet_mac_irq_and_backoff_test
    import emib_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [5:0] pulse = 6'h00;
    logic [31:0] avs_readdata, m_flags, r;
    logic avs_waitrequest, rx_packet_ok, tx_start, tx_collision, irq;
    logic in_collision_window, retry_abort;
    logic [6:0] back_to_back_gap_field;
    logic [5:0] collision_slot_length;
    logic [3:0] retry_limit;
    logic [7:0] descriptor_buffer_count, base;
    logic [31:0] m [2];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    always #10 clk_sys = ~clk_sys;

    emib_core i_emib_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_dma_bus_err(pulse[0]),
        .rx_dma_bus_err(pulse[1]), .rx_packet_ok(rx_packet_ok), .desc_count_inc(pulse[2]),
        .tx_start(tx_start), .tx_collision(tx_collision),
        .back_to_back_gap_field(back_to_back_gap_field),
        .collision_slot_length(collision_slot_length), .retry_limit(retry_limit),
        .descriptor_buffer_count(descriptor_buffer_count),
        .in_collision_window(in_collision_window), .retry_abort(retry_abort), .irq(irq));
    emib_phy_model i_emib_phy_model (.clk_sys(clk_sys), .ev_req(pulse[5:3]),
        .rx_packet_ok(rx_packet_ok), .tx_start(tx_start), .tx_collision(tx_collision));

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(nm, q, exp);
    endtask

    task automatic chk_irq(input logic exp);
        @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    // one-cycle event pulse on the chosen source
    task automatic pls(input int b);
        @(posedge clk_sys);
        pulse <= 6'(1 << b);
        @(posedge clk_sys);
        pulse <= 6'h00;
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        void'($urandom(32'haded));
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        m[0] = 32'h0000_0012;
        m[1] = 32'h0000_370F;
        m_flags = 32'h0000_0200;
        rd("flags", OFS_IRQ_FLAGS, m_flags);
        chk_irq(1'b1);
        pls(0);
        pls(1);
        pls(3);
        pls(2);
        m_flags = 32'h0000_6080;
        wr(OFS_IRQ_FLAGS + 8'h8, 32'h0000_0300, 4'hF);
        rd("flags", OFS_IRQ_FLAGS, m_flags);
        rd("count", OFS_STATUS, 32'h0001_0000);
        foreach (m_flags[b]) if (m_flags[b]) begin
            wr(OFS_IRQ_FLAGS + 8'h4, 32'(1 << b), 4'hF);
            m_flags[b] = 1'b0;
            rd("flags", OFS_IRQ_FLAGS, m_flags);
        end
        chk_irq(1'b0);
        wr(OFS_WMARK_CFG, 32'h0002_0000, 4'hF);
        pls(2);
        rd("flags", OFS_IRQ_FLAGS, 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0001, 4'hF);
        rd("flags", OFS_IRQ_FLAGS, 32'h0000_0000);
        rd("count", OFS_STATUS, 32'h0001_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0000, 4'hF);
        pls(3);
        chk_irq(1'b0);
        wr(OFS_IRQ_MASK + 8'h8, 32'h0000_0080, 4'hF);
        chk_irq(1'b1);
        wr(OFS_IRQ_FLAGS + 8'h4, 32'h0000_0080, 4'hF);
        chk_irq(1'b0);
        // write, clear, set and invert on both timing registers
        for (int j = 0; j < 2; j++) begin
            base = j ? OFS_COLL_CFG : OFS_GAP_CFG;
            for (int i = 0; i < 4; i++) begin
                r = $urandom;
                wr(base + 8'(4 * i), r, 4'hF);
                case (i)
                    0: m[j] = r;
                    1: m[j] &= ~r;
                    2: m[j] |= r;
                    default: m[j] ^= r;
                endcase
                m[j] &= j ? COLL_MASK : 32'h0000_007F;
                rd("cfg", base, m[j]);
            end
        end
        chk("gap_port", {25'h0, back_to_back_gap_field}, m[0]);
        chk("coll_port", {18'h0, collision_slot_length, 4'h0, retry_limit}, m[1]);
        wr(OFS_COLL_CFG, 32'hFFFF_FFFF, 4'h1);
        rd("coll", OFS_COLL_CFG, m[1]);
        wr(OFS_COLL_CFG, 32'h0000_0000, 4'h3);
        rd("coll", OFS_COLL_CFG, 32'h0000_0000);
        rd("unmapped", 8'h70, 32'h0000_0000);
        wr(OFS_GAP_CFG, 32'h0000_0015, 4'hF);
        rd("gap", OFS_GAP_CFG, 32'h0000_0015);
        wr(OFS_GAP_CFG, 32'h0000_0012, 4'h3);
        rd("gap", OFS_GAP_CFG, 32'h0000_0012);
        // two retries allowed, the third collision inside the window aborts
        wr(OFS_COLL_CFG, 32'h0000_3702, 4'hF);
        pls(4);
        repeat (2) @(posedge clk_sys);
        chk("in_win", {31'h0, in_collision_window}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            pls(5);
            repeat (2) @(posedge clk_sys);
            chk("abort", {31'h0, retry_abort}, 32'(k == 2));
        end
        repeat (60) @(posedge clk_sys);
        chk("in_win", {31'h0, in_collision_window}, 32'h0000_0000);
        results();
    end
endmodule

bind emib_core emib_core_assertions #(.CNT_W(CNT_W)) i_emib_core_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .desc_count_inc(desc_count_inc),
    .back_to_back_gap_field(back_to_back_gap_field),
    .collision_slot_length(collision_slot_length), .retry_limit(retry_limit),
    .descriptor_buffer_count(descriptor_buffer_count), .irq(irq));
`default_nettype wire
